// >>> pip_top.sv
/*
  Interrupt pending logic: hardware, software, timer and nonmaskable.
  Assumes all inputs are synchronous to sys_clk_i; the count register,
  compare register and performance counter overflows come from elsewhere.
*/
`timescale 1ns/1ps
module pip_top #(
  parameter logic [pip_pkg::TGT_W-1:0] MY_TARGET = pip_pkg::ID_RST
) (
  // Clock and reset
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_n_i,
  // System bus address cycle
  input  wire logic                         int_cmd_i,
  input  wire logic [pip_pkg::BUS_W-1:0]    system_addr_data_bus_i,
  // Software pending write
  input  wire logic                         sw_wr_i,
  input  wire logic [pip_pkg::SW_INT_N-1:0] sw_wdata_i,
  // Timer sources
  input  wire logic [pip_pkg::CNT_W-1:0]    count_i,
  input  wire logic [pip_pkg::CNT_W-1:0]    compare_i,
  input  wire logic [1:0]                   perf_ovf_i,
  input  wire logic                         timer_clr_i,
  // Nonmaskable pin
  input  wire logic                         nonmaskable_request_n_i,
  // Outputs
  output logic [pip_pkg::CAUSE_W-1:0]       interrupt_pending_field_o,
  output logic [pip_pkg::HW_INT_N-1:0]      hardware_interrupt_pending_o,
  output logic                              nmi_o
);
  import pip_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  pip_req_if req ();

  pip_req_dec u_dec (
    .int_cmd_i   (int_cmd_i),
    .bus_i       (system_addr_data_bus_i),
    .my_target_i (MY_TARGET),
    .req         (req)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pending state, next values and per-bit update strobes.
  logic [HW_INT_N-1:0] hw_reg;
  logic [HW_INT_N-1:0] hw_next;
  logic [HW_INT_N-1:0] hw_upd;
  logic [SW_INT_N-1:0] sw_reg;
  logic [SW_INT_N-1:0] sw_next;
  logic                tmr_reg;
  logic                tmr_next;
  logic                tmr_set;
  logic                cnt_match;
  logic                ovf_any;
  logic                nmi_level;
  logic                nmi_prev_reg;
  logic                nmi_next;
  logic [CAUSE_W-1:0]  cause_next;

  ////////////////////////////////////////////////////////////////////////////
  // Hardware pending bits, one slice per bit.

  // Level-sensitive: a bit holds until the agent sends a clearing request.
  // Each bit has its own enable, so one request may set some bits and clear
  // others in the same cycle.
  for (genvar gi = 0; gi < HW_INT_N; gi++) begin : g_hw_bit

    assign hw_upd[gi]  = req.hit && req.wen[gi];

    assign hw_next[gi] = hw_upd[gi] ? req.val[gi] : hw_reg[gi];

    always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
        hw_reg[gi] <= HW_RST[gi];
      end else begin
        hw_reg[gi] <= hw_next[gi];
      end
    end

  end : g_hw_bit

  ////////////////////////////////////////////////////////////////////////////
  // Software pending bits.

  // Written whole by the move-to instruction; there is no per-bit enable.
  always_comb begin
    sw_next = sw_reg;
    if (sw_wr_i) begin
      sw_next = sw_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sw_reg <= SW_RST;
    end else begin
      sw_reg <= sw_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer pending bit.

  assign cnt_match = (count_i == compare_i);
  assign ovf_any   = |perf_ovf_i;
  assign tmr_set   = cnt_match || ovf_any;

  // Set wins over clear so a match in the clearing cycle is not lost.
  always_comb begin
    tmr_next = tmr_reg;
    if (tmr_set) begin
      tmr_next = 1'b1;
    end else if (timer_clr_i) begin
      tmr_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      tmr_reg <= 1'b0;
    end else begin
      tmr_reg <= tmr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nonmaskable request.

  // The previous level resets to the idle level, so a release with the pin
  // high gives no false edge; a pin already low at release does count.
  assign nmi_level = !nonmaskable_request_n_i;
  assign nmi_next  = nmi_level && !nmi_prev_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      nmi_prev_reg <= 1'b0;
    end else begin
      nmi_prev_reg <= nmi_level;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      nmi_o <= 1'b0;
    end else begin
      nmi_o <= nmi_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cause view.

  // Built from the next values so the view never lags the pending state.
  always_comb begin
    cause_next                           = '0;
    cause_next[CAUSE_HW_LSB +: HW_INT_N] = hw_next;
    cause_next[CAUSE_SW_LSB +: SW_INT_N] = sw_next;
    cause_next[CAUSE_TMR]                = tmr_next;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      interrupt_pending_field_o <= '0;
    end else begin
      interrupt_pending_field_o <= cause_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      hardware_interrupt_pending_o <= HW_RST;
    end else begin
      hardware_interrupt_pending_o <= hw_next;
    end
  end

endmodule : pip_top

// >>> pip_pkg.sv
/*
  Constants, field positions and reset values for the processor interrupt
  posting logic.
  Assumes a single system bus clock domain and a synchronous reset.
*/
// What this block does
// - Interrupt request is one address cycle only.
// - Act only when target field selects us.
// - Bits 20:16 enable writes of bits 4:0.
// - Level pending bits read at cause 14:10.
// - Every reset clears hardware pending bits.
// - Two software bits at cause 9:8, writable.
// - Count equals compare sets timer bit 15.
// - Performance counter overflow also sets timer bit.
// - Nonmaskable recognised in first asserted cycle.
package pip_pkg;

  localparam int unsigned BUS_W        = 64;
  localparam int unsigned HW_INT_N     = 5;
  localparam int unsigned SW_INT_N     = 2;
  localparam int unsigned TGT_W        = 4;
  localparam int unsigned CNT_W        = 32;
  localparam int unsigned CAUSE_W      = 16;

  localparam int unsigned TGT_LSB      = 60;
  localparam int unsigned WEN_LSB      = 16;
  localparam int unsigned VAL_LSB      = 0;

  localparam int unsigned CAUSE_SW_LSB = 8;
  localparam int unsigned CAUSE_HW_LSB = 10;
  localparam int unsigned CAUSE_TMR    = 15;

  localparam logic [HW_INT_N-1:0] HW_RST  = 5'h00;
  localparam logic [SW_INT_N-1:0] SW_RST  = 2'h0;
  localparam logic [TGT_W-1:0]    ID_RST  = 4'h1;

endpackage : pip_pkg

// >>> pip_req_if.sv
/*
  Decoded interrupt request passed from the bus decoder to the pending logic.
  Assumes one clock; the decoder drives, the core consumes.
*/
`timescale 1ns/1ps
interface pip_req_if;
  import pip_pkg::*;
  logic                hit;
  logic [HW_INT_N-1:0] wen;
  logic [HW_INT_N-1:0] val;
  modport dec (output hit, output wen, output val);
  modport core (input hit, input wen, input val);
endinterface : pip_req_if

// >>> pip_req_dec.sv
/*
  Decoder for external interrupt request address cycles.
  Assumes the bus command has already been classified as an interrupt
  request; the address cycle alone carries everything.
*/
`timescale 1ns/1ps
module pip_req_dec (
  // Bus side
  input  wire logic                      int_cmd_i,
  input  wire logic [pip_pkg::BUS_W-1:0] bus_i,
  input  wire logic [pip_pkg::TGT_W-1:0] my_target_i,
  // Core side
  pip_req_if.dec                         req
);
  import pip_pkg::*;

  logic [TGT_W-1:0] tgt;

  // A request is complete in its single address cycle; nothing waits for data.
  assign tgt     = bus_i[TGT_LSB +: TGT_W];
  // Targets are a bit mask so one request may address several processors.
  assign req.hit = int_cmd_i && ((tgt & my_target_i) != '0);
  assign req.wen = bus_i[WEN_LSB +: HW_INT_N];
  assign req.val = bus_i[VAL_LSB +: HW_INT_N];

endmodule : pip_req_dec

// >>> pip_checker.sv
/* Assertions on the pip_top ports.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module pip_checker #(
  parameter logic [3:0] MY_TARGET = 4'h1
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Inputs of the watched block
  input  wire logic        int_cmd_i,
  input  wire logic [63:0] system_addr_data_bus_i,
  input  wire logic        sw_wr_i,
  input  wire logic [1:0]  sw_wdata_i,
  input  wire logic [31:0] count_i,
  input  wire logic [31:0] compare_i,
  input  wire logic [1:0]  perf_ovf_i,
  input  wire logic        timer_clr_i,
  input  wire logic        nonmaskable_request_n_i,
  // Outputs of the watched block
  input  wire logic [15:0] interrupt_pending_field_o,
  input  wire logic [4:0]  hardware_interrupt_pending_o,
  input  wire logic        nmi_o
);
  wire [63:0] b   = system_addr_data_bus_i;
  wire [15:0] f   = interrupt_pending_field_o;
  wire [4:0]  hw  = hardware_interrupt_pending_o;
  wire        hit = int_cmd_i && |(b[63:60] & MY_TARGET);
  logic [4:0] hw_exp;
  always_ff @(posedge sys_clk_i) begin
    hw_exp <= (hw & ~b[20:16]) | (b[4:0] & b[20:16]);
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // The sampled reset stands in the antecedents: at a release edge the disable
  // already sees reset high while the design still applied reset.
  hw_write_a: assert property (rst_n_i && hit |=> hw == hw_exp)
    else $error("hw write");
  miss_keep_a: assert property (rst_n_i && !hit |=> $stable(hw))
    else $error("hw moved");
  cause_view_a: assert property (f[14:10] == hw && f[7:0] == 8'h00)
    else $error("view");
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_n_i |=> f == 16'h0000 && hw == 5'h00 && !nmi_o)
    else $error("reset");
  sw_write_a: assert property (rst_n_i && sw_wr_i |=> f[9:8] == $past(sw_wdata_i))
    else $error("sw");
  timer_match_a: assert property (rst_n_i && count_i == compare_i |=> f[15])
    else $error("match");
  perf_set_a: assert property (rst_n_i && |perf_ovf_i |=> f[15])
    else $error("overflow");
  nmi_first_a: assert property (rst_n_i && $fell(nonmaskable_request_n_i) |=> nmi_o)
    else $error("nmi");
  nmi_once_a: assert property (!$fell(nonmaskable_request_n_i) |=> !nmi_o)
    else $error("re");
endmodule : pip_checker
bind pip_top pip_checker #(
  .MY_TARGET (MY_TARGET)
) chk_u (
  .sys_clk_i                    (sys_clk_i),
  .rst_n_i                      (rst_n_i),
  .int_cmd_i                    (int_cmd_i),
  .system_addr_data_bus_i       (system_addr_data_bus_i),
  .sw_wr_i                      (sw_wr_i),
  .sw_wdata_i                   (sw_wdata_i),
  .count_i                      (count_i),
  .compare_i                    (compare_i),
  .perf_ovf_i                   (perf_ovf_i),
  .timer_clr_i                  (timer_clr_i),
  .nonmaskable_request_n_i      (nonmaskable_request_n_i),
  .interrupt_pending_field_o    (interrupt_pending_field_o),
  .hardware_interrupt_pending_o (hardware_interrupt_pending_o),
  .nmi_o                        (nmi_o)
);

// >>> pip_agent.sv
/* External agent: posts interrupt requests and the nonmaskable pin.
   Assumes its tasks are called from the bench clock domain. */
`timescale 1ns/1ps
module pip_agent (
  input  wire logic        sys_clk_i,
  output logic             int_cmd_o = 1'b0,
  output logic [63:0]      bus_o = 64'h0,
  output logic             nmi_n_o = 1'b1
);
  // One address cycle only; the released bus shows junk, not the last value.
  task automatic post(input logic [3:0] tgt, input logic [4:0] wen, val);
    @(posedge sys_clk_i) int_cmd_o <= 1'b1;
    bus_o <= {tgt, 39'h0, wen, 11'h0, val};
    @(posedge sys_clk_i) int_cmd_o <= 1'b0;
    bus_o <= ~bus_o;
  endtask : post
  // Low for n cycles, then high for at least one before any repost.
  task automatic nmi(input int n);
    @(posedge sys_clk_i) nmi_n_o <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
    nmi_n_o <= 1'b1;
    @(posedge sys_clk_i);
  endtask : nmi
endmodule : pip_agent

// >>> tb_top.sv
/* Self-checking bench for pip_top.
   Assumes pip_agent drives the bus and the nonmaskable pin. */
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, sw_wr_i = 1'b0, timer_clr_i = 1'b0;
  logic [1:0] sw_wdata_i = 2'h0, perf_ovf_i = 2'h0;
  logic [31:0] count_i = 32'h0, compare_i = 32'h1;
  logic int_cmd, nmi_n, nmi_o;
  logic [63:0] bus;
  logic [15:0] f;
  logic [4:0] hw;
  int failures = 0, checks_done = 0, pulses = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (nmi_o === 1'b1) pulses <= pulses + 1;
  pip_agent agent_u (.sys_clk_i(sys_clk_i), .int_cmd_o(int_cmd), .bus_o(bus), .nmi_n_o(nmi_n));
  pip_top dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .int_cmd_i(int_cmd),
    .system_addr_data_bus_i(bus), .sw_wr_i(sw_wr_i), .sw_wdata_i(sw_wdata_i),
    .count_i(count_i), .compare_i(compare_i), .perf_ovf_i(perf_ovf_i),
    .timer_clr_i(timer_clr_i), .nonmaskable_request_n_i(nmi_n),
    .interrupt_pending_field_o(f), .hardware_interrupt_pending_o(hw), .nmi_o(nmi_o));
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic t_hw();
    agent_u.post(4'h1, 5'h1f, 5'h05);
    #1 check("hw set", 16'(f[14:10]), 16'h0005);
    agent_u.post(4'h3, 5'h03, 5'h1a);
    #1 check("hw subset", 16'(hw), 16'h0006);
    agent_u.post(4'he, 5'h1f, 5'h1f);
    #1 check("hw miss", 16'(hw), 16'h0006);
    agent_u.post(4'hf, 5'h06, 5'h00);
    #1 check("hw clear", 16'(hw), 16'h0000);
    agent_u.post(4'h1, 5'h1f, 5'h1f);
    @(posedge sys_clk_i) rst_n_i <= 1'b0;
    @(posedge sys_clk_i) rst_n_i <= 1'b1;
    #1 check("hw reset", f, 16'h0000);
  endtask : t_hw
  task automatic t_sw_timer();
    @(posedge sys_clk_i) sw_wr_i <= 1'b1;
    sw_wdata_i <= 2'h2;
    compare_i <= 32'h0;
    @(posedge sys_clk_i) sw_wr_i <= 1'b0;
    compare_i <= 32'h1;
    #1 check("sw and timer", f, 16'h8200);
    @(posedge sys_clk_i) timer_clr_i <= 1'b1;
    @(posedge sys_clk_i) timer_clr_i <= 1'b0;
    #1 check("timer clear", 16'(f[15]), 16'h0000);
    @(posedge sys_clk_i) perf_ovf_i <= 2'h2;
    @(posedge sys_clk_i) perf_ovf_i <= 2'h0;
    timer_clr_i <= 1'b1;
    #1 check("overflow", 16'(f[15]), 16'h0001);
    @(posedge sys_clk_i) timer_clr_i <= 1'b0;
    perf_ovf_i <= 2'h1;
    #1 check("clear again", 16'(f[15]), 16'h0000);
    @(posedge sys_clk_i) perf_ovf_i <= 2'h0;
    #1 check("overflow 0", 16'(f[15]), 16'h0001);
  endtask : t_sw_timer
  task automatic t_nmi();
    agent_u.nmi(3);
    agent_u.nmi(1);
    repeat (2) @(posedge sys_clk_i);
    #1 check("nmi pulses", 16'(pulses), 16'h0002);
  endtask : t_nmi
  task automatic give_verdict();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1 check("reset view", f, 16'h0000);
    t_hw();
    t_sw_timer();
    t_nmi();
    give_verdict();
  end
  initial begin
    repeat (400) @(posedge sys_clk_i);
    failures++;
    give_verdict();
  end
endmodule : tb_top
